// File: rtl/card_serial.sv
// Smart card serial unit: APB registers, card clock, character engine
`timescale 1ns/10ps

module card_serial (
  // Clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CLK_EN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Card clock pin
  output logic             SCK_OUT,
  output logic             SCK_OE,
  // Card data pin, open drain
  input  wire logic        DATA_IN,
  output logic             DATA_OUT,
  output logic             DATA_OE,
  // Interrupt requests
  output logic             TX_IRQ,
  output logic             RX_FULL_IRQ,
  output logic             ERROR_IRQ
);
  import card_serial_pkg::*;

  // Address decode for the slave error answer to reads and writes
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == MODE_OFS) || (a == CARD_OFS) || (a == CTRL_OFS) ||
              (a == STAT_OFS) || (a == TXD_OFS) || (a == RXD_OFS) ||
              (a == PORT_OFS);
  endfunction

  // Parity of a character, even unless odd is selected
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction

  // Register state
  logic [7:0]  mode_r, mode_nxt;
  logic [7:0]  card_r, card_nxt;
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [7:0]  stat_r, stat_nxt;
  logic [7:0]  port_r, port_nxt;
  logic [7:0]  txd_r, txd_nxt;
  logic [7:0]  rxd_r, rxd_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        tx_irq_r, tx_irq_nxt;
  logic        rxf_irq_r, rxf_irq_nxt;
  logic        err_irq_r, err_irq_nxt;
  logic        wr_en, txd_wr;

  // Link side state
  logic        d1_r, d2_r, d3_r;
  logic        line, fall, tick;
  logic [2:0]  div_r, div_nxt;
  logic        run_r, run_nxt;
  logic        sck_r, sck_nxt;
  logic        sck_oe_r, sck_oe_nxt;
  link_state_e state_r, state_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [8:0]  etu_r, etu_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic        err_r, err_nxt;
  logic        pend_r, pend_nxt;
  logic        oe_r, oe_nxt;
  logic        dout_r;
  logic        mid, end_bit, rx_done, rx_bad, tx_ok, tx_bad;

  // Control bits in short form
  logic odd_par, tx_irq_enable, rx_irq_enable, te, re, cklv, ckoe, smif, pdir, plvl;
  assign odd_par = mode_r[MODE_ODD_BIT];
  assign smif    = card_r[CARD_SMIF_BIT];
  assign tx_irq_enable     = ctrl_r[CTRL_TIE_BIT];
  assign rx_irq_enable     = ctrl_r[CTRL_RIE_BIT];
  assign te      = ctrl_r[CTRL_TE_BIT];
  assign re      = ctrl_r[CTRL_RE_BIT];
  assign cklv    = ctrl_r[CTRL_CKLV_BIT];
  assign ckoe    = ctrl_r[CTRL_CKOE_BIT];
  assign pdir    = port_r[PORT_DIR_BIT];
  assign plvl    = port_r[PORT_LVL_BIT];

  // Write lands at the edge where the master sees pready
  assign wr_en  = PSEL && PENABLE && PWRITE && pready_r;
  assign txd_wr = wr_en && (PADDR == TXD_OFS);

  // Register file and APB answer
  always_comb begin
    mode_nxt    = mode_r;
    card_nxt    = card_r;
    ctrl_nxt    = ctrl_r;
    port_nxt    = port_r;
    txd_nxt     = txd_r;
    rxd_nxt     = rxd_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    // One wait state keeps prdata a flip-flop output
    pready_nxt  = PSEL && PENABLE && !pready_r;
    if (PSEL && PENABLE && !pready_r) begin
      pslverr_nxt = !reg_hit(PADDR);
      case (PADDR)
        MODE_OFS: prdata_nxt = {24'h000000, mode_r};
        CARD_OFS: prdata_nxt = {24'h000000, card_r};
        CTRL_OFS: prdata_nxt = {24'h000000, ctrl_r};
        STAT_OFS: prdata_nxt = {24'h000000, stat_r};
        TXD_OFS:  prdata_nxt = {24'h000000, txd_r};
        RXD_OFS:  prdata_nxt = {24'h000000, rxd_r};
        PORT_OFS: prdata_nxt = {24'h000000, port_r};
        default:  prdata_nxt = 32'h00000000;
      endcase
    end
    if (wr_en) begin
      case (PADDR)
        MODE_OFS: mode_nxt = PWDATA[7:0];
        CARD_OFS: card_nxt = PWDATA[7:0];
        CTRL_OFS: ctrl_nxt = PWDATA[7:0];
        PORT_OFS: port_nxt = PWDATA[7:0];
        TXD_OFS:  txd_nxt  = PWDATA[7:0];
        default:  ;
      endcase
    end
    // Status: software writes 0 to clear; a hardware set wins the race
    stat_nxt = stat_r;
    if (wr_en && (PADDR == STAT_OFS))
      stat_nxt = stat_r & (PWDATA[7:0] | ~STAT_MASK);
    if (txd_wr)
      stat_nxt[STAT_TX_END_FLAG_BIT] = 1'b0;
    if (rx_done) begin
      if (rx_bad)
        stat_nxt[STAT_PER_BIT] = 1'b1;
      else if (stat_r[STAT_RX_FULL_FLAG_BIT])
        stat_nxt[STAT_OVERRUN_FLAG_BIT] = 1'b1;
      else
        stat_nxt[STAT_RX_FULL_FLAG_BIT] = 1'b1;
      // Overrun keeps the unread character
      if (rx_bad || !stat_r[STAT_RX_FULL_FLAG_BIT])
        rxd_nxt = sh_r;
    end
    if (tx_bad)
      stat_nxt[STAT_ERS_BIT] = 1'b1;
    if (tx_ok)
      stat_nxt[STAT_TX_END_FLAG_BIT] = 1'b1;
    // Interrupt requests follow the flags
    tx_irq_nxt  = stat_nxt[STAT_TX_END_FLAG_BIT] && tx_irq_enable;
    rxf_irq_nxt = stat_nxt[STAT_RX_FULL_FLAG_BIT] && rx_irq_enable;
    err_irq_nxt = rx_irq_enable && (stat_nxt[STAT_OVERRUN_FLAG_BIT] ||
                  stat_nxt[STAT_PER_BIT] || stat_nxt[STAT_ERS_BIT]);
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      mode_r    <= MODE_RST;
      card_r    <= CARD_RST;
      ctrl_r    <= CTRL_RST;
      stat_r    <= STAT_RST;
      port_r    <= PORT_RST;
      txd_r     <= DATA_RST;
      rxd_r     <= DATA_RST;
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      tx_irq_r  <= 1'b0;
      rxf_irq_r <= 1'b0;
      err_irq_r <= 1'b0;
    end else if (CLK_EN) begin
      mode_r    <= mode_nxt;
      card_r    <= card_nxt;
      ctrl_r    <= ctrl_nxt;
      stat_r    <= stat_nxt;
      port_r    <= port_nxt;
      txd_r     <= txd_nxt;
      rxd_r     <= rxd_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      tx_irq_r  <= tx_irq_nxt;
      rxf_irq_r <= rxf_irq_nxt;
      err_irq_r <= err_irq_nxt;
    end
  end

  // Data pin synchroniser; the second stage feeds logic, the third only the falling-edge detect
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      d1_r <= 1'b1;
      d2_r <= 1'b1;
      d3_r <= 1'b1;
    end else if (CLK_EN) begin
      d1_r <= DATA_IN;
      d2_r <= d1_r;
      d3_r <= d2_r;
    end
  end
  assign line = d2_r;
  assign fall = d3_r && !d2_r;

  // Card clock divider; each period is one base clock pulse
  always_comb begin
    div_nxt = (div_r == SCK_DIV_LAST) ? 3'h0 : div_r + 3'h1;
    tick    = (div_r == SCK_DIV_LAST);
    // Enable is only looked at on a period boundary, so a stop or
    // restart never produces a short pulse
    run_nxt = tick ? ckoe : run_r;
    if (run_nxt)
      sck_nxt = (div_nxt < SCK_HALF);
    else
      sck_nxt = cklv;
    sck_oe_nxt = smif || pdir;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      div_r    <= 3'h0;
      run_r    <= 1'b0;
      sck_r    <= 1'b0;
      sck_oe_r <= 1'b0;
    end else if (CLK_EN) begin
      div_r    <= div_nxt;
      run_r    <= run_nxt;
      sck_r    <= sck_nxt;
      sck_oe_r <= sck_oe_nxt;
    end
  end

  // Character engine for both directions
  assign mid     = tick && (etu_r == SAMPLE_AT);
  assign end_bit = tick && (etu_r == ETU_LAST);

  always_comb begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    etu_nxt   = etu_r;
    sh_nxt    = sh_r;
    err_nxt   = err_r;
    oe_nxt    = 1'b0;
    pend_nxt  = pend_r || txd_wr;
    rx_done   = 1'b0;
    rx_bad    = 1'b0;
    tx_ok     = 1'b0;
    tx_bad    = 1'b0;
    if (tick)
      etu_nxt = (etu_r == ETU_LAST) ? 9'h000 : etu_r + 9'h001;
    if (end_bit && (bit_r != LAST_IDX))
      bit_nxt = bit_r + 4'h1;
    case (state_r)
      ST_IDLE: begin
        etu_nxt = 9'h000;
        bit_nxt = 4'h0;
        err_nxt = 1'b0;
        // Transmit starts on a base pulse so every bit is whole
        if (smif && re && fall)
          state_nxt = ST_RX;
        else if (smif && te && pend_r && tick) begin
          state_nxt = ST_TX;
          pend_nxt  = txd_wr;
        end
      end
      ST_RX: begin
        if (mid) begin
          if (bit_r == 4'h0) begin
            // Glitch rather than a start bit
            if (line)
              state_nxt = ST_IDLE;
          end else if (bit_r < PAR_IDX) begin
            sh_nxt = {line, sh_r[7:1]};
          end else if (bit_r == PAR_IDX) begin
            rx_done = 1'b1;
            rx_bad  = (line != par_of(sh_r, odd_par));
            err_nxt = rx_bad;
          end
        end
        // Pull the slot low only after a bad character
        if (bit_r == SLOT_IDX)
          oe_nxt = err_r;
        if (end_bit && (bit_r == LAST_IDX))
          state_nxt = ST_IDLE;
      end
      ST_TX: begin
        if (bit_r == 4'h0)
          oe_nxt = 1'b1;
        else if (bit_r < PAR_IDX)
          oe_nxt = !txd_r[3'(bit_r - 4'h1)];
        else if (bit_r == PAR_IDX)
          oe_nxt = !par_of(txd_r, odd_par);
        if (mid && (bit_r == SLOT_IDX))
          err_nxt = !line;
        if (end_bit && (bit_r == LAST_IDX)) begin
          if (err_r) begin
            tx_bad  = 1'b1;
            // Resend the held character, transmit end stays clear
            bit_nxt = 4'h0;
            err_nxt = 1'b0;
          end else begin
            tx_ok     = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Dropping the enables abandons the character
    if (((state_r == ST_TX) && !(smif && te)) ||
        ((state_r == ST_RX) && !(smif && re)))
      state_nxt = ST_IDLE;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
      bit_r   <= 4'h0;
      etu_r   <= 9'h000;
      sh_r    <= 8'h00;
      err_r   <= 1'b0;
      pend_r  <= 1'b0;
      oe_r    <= 1'b0;
      dout_r  <= 1'b0;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      bit_r   <= bit_nxt;
      etu_r   <= etu_nxt;
      sh_r    <= sh_nxt;
      err_r   <= err_nxt;
      pend_r  <= pend_nxt;
      oe_r    <= oe_nxt;
      dout_r  <= 1'b0; // Open drain: the enable alone shapes the line
    end
  end

  // Outputs straight from flip-flops
  assign PRDATA      = prdata_r;
  assign PREADY      = pready_r;
  assign PSLVERR     = pslverr_r;
  assign SCK_OUT     = sck_r;
  assign SCK_OE      = sck_oe_r;
  assign DATA_OUT    = dout_r;
  assign DATA_OE     = oe_r;
  assign TX_IRQ      = tx_irq_r;
  assign RX_FULL_IRQ = rxf_irq_r;
  assign ERROR_IRQ   = err_irq_r;

endmodule

// File: include/card_serial_pkg.sv
// Constants, register map and state codes for the smart card serial unit
package card_serial_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] MODE_OFS  = 8'h00;
  localparam logic [7:0] CARD_OFS  = 8'h04;
  localparam logic [7:0] CTRL_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h0C;
  localparam logic [7:0] TXD_OFS   = 8'h10;
  localparam logic [7:0] RXD_OFS   = 8'h14;
  localparam logic [7:0] PORT_OFS  = 8'h18;

  // serial_mode_reg fields
  localparam int MODE_ODD_BIT = 0;
  // card_mode_reg fields
  localparam int CARD_SMIF_BIT = 0;
  // serial_control_reg fields
  localparam int CTRL_TIE_BIT  = 7;
  localparam int CTRL_RIE_BIT  = 6;
  localparam int CTRL_TE_BIT   = 5;
  localparam int CTRL_RE_BIT   = 4;
  localparam int CTRL_CKLV_BIT = 1;
  localparam int CTRL_CKOE_BIT = 0;
  // serial_status_reg fields
  localparam int STAT_RX_FULL_FLAG_BIT = 6;
  localparam int STAT_OVERRUN_FLAG_BIT = 5;
  localparam int STAT_ERS_BIT  = 4;
  localparam int STAT_PER_BIT  = 3;
  localparam int STAT_TX_END_FLAG_BIT = 2;
  // serial_port_reg fields
  localparam int PORT_DIR_BIT = 1;
  localparam int PORT_LVL_BIT = 0;

  // Reset values and the status clear mask
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CARD_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h04;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] STAT_MASK = 8'h7C;

  // Timing: system clock, card clock, bit period
  localparam int CLK_HZ        = 20000000;
  localparam int SCK_PERIOD_NS = 400;
  localparam int SCK_DIV_INT   = (SCK_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [2:0] SCK_DIV_LAST = 3'(SCK_DIV_INT - 1);
  localparam logic [2:0] SCK_HALF     = 3'(SCK_DIV_INT / 2);
  localparam int ETU_BASE      = 372;
  localparam int SAMPLE_PULSE  = 186;
  localparam logic [8:0] ETU_LAST  = 9'(ETU_BASE - 1);
  localparam logic [8:0] SAMPLE_AT = 9'(SAMPLE_PULSE - 1);
  localparam int FRAME_BITS    = 10;
  localparam logic [3:0] PAR_IDX  = 4'(FRAME_BITS - 1);
  localparam logic [3:0] SLOT_IDX = 4'(FRAME_BITS);
  localparam logic [3:0] LAST_IDX = 4'(FRAME_BITS + 1);

  // Link state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX   = 2'b01,
    ST_TX   = 2'b10
  } link_state_e;

endpackage

// File: verif/card_serial_monitor.sv
// Port-level checker for the smart card serial unit
`timescale 1ns/10ps
module card_serial_monitor (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RST_N,
  // APB slave
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Card pins and requests
  input wire logic        SCK_OUT,
  input wire logic        SCK_OE,
  input wire logic        DATA_OUT,
  input wire logic        DATA_OE,
  input wire logic        TX_IRQ,
  input wire logic        RX_FULL_IRQ,
  input wire logic        ERROR_IRQ
);
  import card_serial_pkg::*;
  localparam int BIT_CYC = ETU_BASE * SCK_DIV_INT;
  logic [15:0] run_r;
  logic [15:0] run_nxt;

  // Cycles the line has been pulled; pulls must be whole bits
  always_comb run_nxt = DATA_OE ? run_r + 16'h1 : 16'h0;
  always_ff @(posedge CLOCK) run_r <= run_nxt;

  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // Bus answer timing and contents
  pready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  pready_wait_a: assert property ((PSEL && !PENABLE) ##1
    (PSEL && PENABLE) |=> PREADY) else $error("wait state wrong");
  bad_addr_a: assert property (PREADY && PADDR[1:0] == 2'h0
    |-> PSLVERR == (PADDR > PORT_OFS)) else $error("slave error wrong");
  rd_upper_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  // Card pins, transmit request and state after reset
  drain_only_a: assert property (DATA_OUT == 1'h0)
    else $error("data line driven high");
  pull_length_a: assert property ($fell(DATA_OE) |->
    run_r % BIT_CYC == 0) else $error("pull not whole bits");
  sck_low_a: assert property ($fell(SCK_OUT) |-> !SCK_OUT [*4])
    else $error("clock low phase cut");
  sck_high_a: assert property ($rose(SCK_OUT) |-> SCK_OUT [*4])
    else $error("clock high phase cut");
  txd_clear_a: assert property (PREADY && PWRITE &&
    PADDR == TXD_OFS |=> !TX_IRQ) else $error("transmit request stays");
  reset_quiet_a: assert property ($rose(RST_N) |-> !(TX_IRQ ||
    ERROR_IRQ || RX_FULL_IRQ || SCK_OE || DATA_OE || PREADY))
    else $error("outputs active after reset");
  // Main scenarios reached
  cover property ($rose(ERROR_IRQ));
  cover property ($rose(TX_IRQ));
  cover property (PREADY && PSLVERR);
endmodule

bind card_serial card_serial_monitor mon (
  .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .TX_IRQ(TX_IRQ),
  .RX_FULL_IRQ(RX_FULL_IRQ), .ERROR_IRQ(ERROR_IRQ)
);

// File: verif/card_model.sv
// Behavioural smart card on the open-drain data line
`timescale 1ns/10ps
module card_model (
  // Card clock and shared line
  input  wire logic sck,
  input  wire logic line,
  output logic      pull,
  // Parity sense and forced error signal
  input  wire logic odd,
  input  wire logic nak
);
  logic [7:0] got;
  logic       ok;
  logic       busy;
  logic       err_seen;

  // Whole card clock periods
  task automatic ticks(input int c);
    repeat (c) @(posedge sck);
  endtask

  // Send a character, then listen to the error slot
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {^d ^ odd ^ bad, d, 1'h0};
    busy = 1'h1;
    for (int k = 0; k < 10; k++) begin
      pull = ~f[k];
      ticks(372);
    end
    pull = 1'h0;
    ticks(186);
    err_seen = ~line;
    ticks(186);
    busy = 1'h0;
  endtask

  // Take each character; a bad one or a forced one is refused
  initial begin
    pull = 1'h0;
    busy = 1'h0;
    forever begin
      @(negedge line iff !busy);
      ticks(186);
      for (int k = 0; k < 8; k++) begin
        ticks(372);
        got[k] = line;
      end
      ticks(372);
      ok = (^got ^ line) == odd;
      ticks(186);
      pull = nak || !ok;
      ticks(372);
      pull = 1'h0;
    end
  end
endmodule

// File: verif/card_serial_tb.sv
// Self-checking bench for the smart card serial unit
`timescale 1ns/10ps
module card_serial_tb;
  import card_serial_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } row_s;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        sck_out, sck_oe, data_out, data_oe, tx_irq, rx_full_irq;
  logic        error_irq, pull, odd, nak, rerr, clk_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          fail_count, cmp_count;
  wire         line = !(data_oe || pull);
  // Pin level first, then mode, then clock out
  row_s rows [7] = '{
    '{PORT_OFS, 32'h3, 32'h3, 1'h0},
    '{CTRL_OFS, 32'h2, 32'h2, 1'h0},
    '{MODE_OFS, 32'h1, 32'h1, 1'h0},
    '{CARD_OFS, 32'h1, 32'h1, 1'h0},
    '{CTRL_OFS, 32'hE3, 32'hE3, 1'h0},
    '{8'h1C, 32'h55, 32'h0, 1'h1},
    '{STAT_OFS, 32'h7C, 32'h4, 1'h0}
  };

  card_serial uut (
    .CLOCK(clock), .RST_N(rst_n), .CLK_EN(clk_en), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCK_OUT(sck_out), .SCK_OE(sck_oe), .DATA_IN(line),
    .DATA_OUT(data_out), .DATA_OE(data_oe), .TX_IRQ(tx_irq),
    .RX_FULL_IRQ(rx_full_irq), .ERROR_IRQ(error_irq)
  );
  card_model card (.sck(sck_out), .line(line), .pull(pull), .odd(odd),
    .nak(nak));

  // 20 MHz system clock
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  // Compare one value, unknowns must match bit for bit
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'h1 && k < 20);
    chk(pready, 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Read and compare one register
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(rdat, x);
  endtask

  // Bounded wait for the transmit or the error request
  task automatic hold_for(input logic want_tx);
    int c;
    c = 0;
    while ((want_tx ? tx_irq : error_irq) !== 1'h1 && c < 40000) begin
      @(posedge clock);
      c++;
    end
    chk(c < 40000, 1'h1);
  endtask

  // Verdict and end of run
  task automatic test_done;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_n = 1'h0;
    clk_en = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    odd = 1'h1;
    nak = 1'h1;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    foreach (rows[k]) begin
      apb(1'h1, rows[k].a, rows[k].d);
      rd(rows[k].a, rows[k].x);
      chk(rerr, rows[k].e);
    end
    // Card refuses the first frame, the resend goes through
    apb(1'h1, TXD_OFS, 32'hA5);
    rd(STAT_OFS, 32'h0);
    hold_for(1'h0);
    rd(STAT_OFS, 32'h10);
    chk(tx_irq, 1'h0);
    nak <= 1'h0;
    apb(1'h1, STAT_OFS, 32'h0);
    hold_for(1'h1);
    rd(STAT_OFS, 32'h4);
    chk(card.got, 32'hA5);
    chk(card.ok, 1'h1);
    // Card sends a character with bad even parity
    odd <= 1'h0;
    apb(1'h1, MODE_OFS, 32'h0);
    apb(1'h1, CTRL_OFS, 32'hD3);
    card.send(8'h3C, 1'h1);
    chk(error_irq, 1'h1);
    chk(rx_full_irq, 1'h0);
    rd(STAT_OFS, 32'hC);
    rd(RXD_OFS, 32'h3C);
    chk(card.err_seen, 1'h1);
    apb(1'h1, STAT_OFS, 32'h4);
    @(posedge clock);
    chk(error_irq, 1'h0);
    // Stop the clock high for standby, then bring it back
    apb(1'h1, CTRL_OFS, 32'h3);
    apb(1'h1, CTRL_OFS, 32'h2);
    repeat (16) @(posedge clock);
    chk(sck_out, 1'h1);
    apb(1'h1, MODE_OFS, 32'h0);
    apb(1'h1, CARD_OFS, 32'h0);
    apb(1'h1, CARD_OFS, 32'h1);
    apb(1'h1, CTRL_OFS, 32'h3);
    repeat (40) @(posedge clock);
    // Clock enable low freezes the running card clock
    clk_en <= 1'h0;
    @(posedge clock);
    rdat = sck_out;
    repeat (5) @(posedge clock);
    chk(sck_out, rdat);
    clk_en <= 1'h1;
    // Second reset in mid-run
    rst_n <= 1'h0;
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    rd(STAT_OFS, STAT_RST);
    rd(CTRL_OFS, CTRL_RST);
    chk(sck_oe, 1'h0);
    test_done;
  end

  // Cut a hung run short
  initial begin
    repeat (125000) @(posedge clock);
    fail_count++;
    test_done;
  end
endmodule
